// ### core/lsp_uart.v
`timescale 1ns/100ps
`include "lsp_uart_consts.vh"
// Contract
// [RQ1] Received bytes are double buffered.
// [RQ2] Buffer write transmits; read returns receive holding.
// [RQ3] Two mode bits select four modes.
// [RQ4] Filter drops ninth-bit-zero bytes when enabled.
// [RQ5] Shift mode clocks out at core/12.
// [RQ6] Shift data changes rising, sampled falling.
// [RQ7] Shift transmit starts on write, sets tx flag.
// [RQ8] Shift receive needs enable and clear flag.
// [RQ9] Eight-bit mode frame is ten bits.
// [RQ10] Timer1 rate, halved unless doubler set.
// [RQ11] Timer2 selections override timer1 and doubler.
// [RQ12] Nine-bit frames are eleven bits.
// [RQ13] Fixed mode: core/64, or /32 doubled.
// [RQ14] Variable nine-bit mode uses timer rates.
// [RQ15] Ninth transmitted bit from control bit.
// [RQ16] Received ninth bit captured into control.
// [RQ17] No hardware parity checking.
// [RQ18] Tx flag set by hardware, cleared by software.
// [RQ19] Rx flag set by hardware, cleared by software.
// [RQ20] One enabled interrupt from either flag.
// [RQ21] Pins configured externally before shift mode.
// [RQ22] Start edge detect, mid-bit sampling, false-start reject.
// [RQ23] Control register resets to zero.
module lsp_uart (
  input wire REF_CLK_IN,
  input wire NRST_IN,
  input wire CE_IN,
  input wire [7:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [7:0] RDATA_OUT,
  input wire T1_OVF_IN,
  input wire T2_OVF_IN,
  input wire SERIAL_IN_PIN_IN,
  output reg SERIAL_IN_PIN_OUT,
  output reg SERIAL_IN_PIN_OE_OUT,
  output reg SERIAL_OUT_PIN_OUT,
  output reg IRQ_OUT,
  output reg IRQ_PRIO_OUT
);
////////////////////////////////////////////////////////////////////////////////
reg [7:0] ctrl;
reg [7:0] aux;
reg [7:0] rx_hold;
reg rx_s1, rx_s2, rx_prev;
wire wr_ctrl = WR_IN && ADDR_IN == `LSP_ADDR_CONTROL;
wire wr_buf = WR_IN && ADDR_IN == `LSP_ADDR_BUFFER;
wire wr_aux = WR_IN && ADDR_IN == `LSP_ADDR_AUX;
wire [1:0] mode = {ctrl[`LSP_BIT_MODE_HI], ctrl[`LSP_BIT_MODE_LO]}; // see [RQ3]
wire shift_mode = mode == 2'b00;
wire nine_bit = mode[1]; // see [RQ12]
wire doubler = aux[`LSP_BIT_DOUBLER];
////////////////////////////////////////////////////////////////////////////////
// Oversampling ticks: 16 per bit.  Timer overflows are same-clock pulses.
reg [6:0] fix_cnt;
reg t1_half;
reg fix_tick;
wire [6:0] fix_div = doubler ? `LSP_FIX_DIV_FAST : `LSP_FIX_DIV_SLOW; // see [RQ13]
wire t1_tick = T1_OVF_IN && (doubler || t1_half); // see [RQ10]
wire rx_t2 = aux[`LSP_BIT_RXT2];
wire tx_t2 = aux[`LSP_BIT_TXT2];
wire rx_tick = (mode == 2'b10) ? fix_tick : (rx_t2 ? T2_OVF_IN : t1_tick); // see [RQ11] [RQ14]
wire tx_tick = (mode == 2'b10) ? fix_tick : (tx_t2 ? T2_OVF_IN : t1_tick); // see [RQ11] [RQ14]
always @(posedge REF_CLK_IN or negedge NRST_IN) begin
  if (!NRST_IN) begin
    fix_cnt <= 7'h00;
    t1_half <= 1'b0;
    fix_tick <= 1'b0;
  end else if (CE_IN) begin
    if (T1_OVF_IN) begin
      t1_half <= ~t1_half;
    end
    if (fix_cnt + 7'h01 >= fix_div) begin
      fix_cnt <= 7'h00;
      fix_tick <= 1'b1;
    end else begin
      fix_cnt <= fix_cnt + 7'h01;
      fix_tick <= 1'b0;
    end
  end
end
////////////////////////////////////////////////////////////////////////////////
// Shift-mode clock phase: 12 core cycles per shift clock, high half then low.
reg [3:0] sh_cnt;
always @(posedge REF_CLK_IN or negedge NRST_IN) begin
  if (!NRST_IN) begin
    sh_cnt <= 4'h0;
  end else if (CE_IN) begin
    sh_cnt <= (sh_cnt == `LSP_SHIFT_DIV - 4'h1) ? 4'h0 : sh_cnt + 4'h1; // see [RQ5]
  end
end
wire sh_rise = sh_cnt == 4'h0;
wire sh_fall = sh_cnt == 4'h6;
////////////////////////////////////////////////////////////////////////////////
// Transmitter.
reg [10:0] tx_shreg;
reg [3:0] tx_bits;
reg [3:0] tx_sub;
reg tx_busy;
reg set_tx;
always @(posedge REF_CLK_IN or negedge NRST_IN) begin
  if (!NRST_IN) begin
    tx_shreg <= 11'h7FF;
    tx_bits <= 4'h0;
    tx_sub <= 4'h0;
    tx_busy <= 1'b0;
    set_tx <= 1'b0;
  end else if (CE_IN) begin
    set_tx <= 1'b0;
    if (wr_buf && !tx_busy) begin
      tx_busy <= 1'b1; // see [RQ2] [RQ7]
      tx_sub <= 4'h0;
      if (shift_mode) begin
        tx_shreg <= {3'h7, WDATA_IN};
        tx_bits <= 4'h8;
      end else if (nine_bit) begin
        tx_shreg <= {1'b1, ctrl[`LSP_BIT_TX9], WDATA_IN, 1'b0}; // see [RQ12] [RQ15]
        tx_bits <= 4'hB;
      end else begin
        tx_shreg <= {2'h3, WDATA_IN, 1'b0}; // see [RQ9]
        tx_bits <= 4'hA;
      end
    end else if (tx_busy && shift_mode) begin
      if (sh_rise && tx_sub != 4'h0) begin
        tx_shreg <= {1'b1, tx_shreg[10:1]}; // see [RQ6]
        tx_bits <= tx_bits - 4'h1;
        if (tx_bits == 4'h1) begin
          tx_busy <= 1'b0;
          set_tx <= 1'b1; // see [RQ7]
        end
      end else if (sh_rise) begin
        tx_sub <= 4'h1;
      end
    end else if (tx_busy && tx_tick) begin
      tx_sub <= tx_sub + 4'h1;
      if (tx_sub == 4'hF) begin
        tx_shreg <= {1'b1, tx_shreg[10:1]};
        tx_bits <= tx_bits - 4'h1;
        if (tx_bits == 4'h1) begin
          tx_busy <= 1'b0;
          set_tx <= 1'b1;
        end
      end
    end
  end
end
////////////////////////////////////////////////////////////////////////////////
// Receiver.  Serial input is synchronised; only rx_s2 feeds logic.
localparam RX_IDLE = 3'b001;
localparam RX_DATA = 3'b010;
localparam RX_DONE = 3'b100;
reg [2:0] rx_state;
reg [9:0] rx_shreg;
reg [3:0] rx_bits;
reg [3:0] rx_sub;
reg set_rx;
reg set_rx9;
reg rx9_val;
always @(posedge REF_CLK_IN or negedge NRST_IN) begin
  if (!NRST_IN) begin
    rx_s1 <= 1'b1;
    rx_s2 <= 1'b1;
    rx_prev <= 1'b1;
    rx_state <= RX_IDLE;
    rx_shreg <= 10'h000;
    rx_bits <= 4'h0;
    rx_sub <= 4'h0;
    rx_hold <= 8'h00;
    set_rx <= 1'b0;
    set_rx9 <= 1'b0;
    rx9_val <= 1'b0;
  end else if (CE_IN) begin
    rx_s1 <= SERIAL_IN_PIN_IN;
    rx_s2 <= rx_s1;
    rx_prev <= rx_s2;
    set_rx <= 1'b0;
    set_rx9 <= 1'b0;
    case (rx_state)
      RX_IDLE: begin
        rx_sub <= 4'h0;
        if (!ctrl[`LSP_BIT_REN]) begin
          rx_state <= RX_IDLE;
        end else if (shift_mode) begin
          if (!ctrl[`LSP_BIT_RXDONE] && !tx_busy) begin
            rx_state <= RX_DATA; // see [RQ8]
            rx_bits <= 4'h8;
          end
        end else if (rx_prev && !rx_s2) begin
          rx_state <= RX_DATA; // see [RQ22]
          rx_bits <= nine_bit ? 4'hA : 4'h9;
        end
      end
      RX_DATA: begin
        if (shift_mode) begin
          if (sh_fall) begin
            rx_shreg <= {rx_s2, rx_shreg[9:1]}; // see [RQ6]
            rx_bits <= rx_bits - 4'h1;
            if (rx_bits == 4'h1) begin
              rx_state <= RX_DONE;
            end
          end
        end else if (rx_tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == 4'h7) begin
            if (rx_bits == (nine_bit ? 4'hA : 4'h9) && rx_s2) begin
              rx_state <= RX_IDLE; // see [RQ22]
            end else begin
              rx_shreg <= {rx_s2, rx_shreg[9:1]};
              rx_bits <= rx_bits - 4'h1;
              if (rx_bits == 4'h1) begin
                rx_state <= RX_DONE;
              end
            end
          end
        end
      end
      RX_DONE: begin
        rx_state <= RX_IDLE;
        // Second frame can arrive while software still holds the first.
        if (shift_mode) begin
          rx_hold <= rx_shreg[9:2]; // see [RQ1]
          set_rx <= 1'b1; // see [RQ8]
        end else if (!ctrl[`LSP_BIT_RXDONE] &&
                     !(nine_bit && ctrl[`LSP_BIT_MPF] && !rx_shreg[9])) begin // see [RQ4]
          // Nine-bit frames take ten samples, eight-bit frames nine, so data sits lower.
          rx_hold <= nine_bit ? rx_shreg[8:1] : rx_shreg[9:2]; // see [RQ1] [RQ17]
          rx9_val <= rx_shreg[9];
          set_rx9 <= nine_bit; // see [RQ16]
          set_rx <= 1'b1;
        end
      end
      default: begin
        rx_state <= RX_IDLE;
      end
    endcase
  end
end
////////////////////////////////////////////////////////////////////////////////
// Registers.  Hardware set wins over a same-cycle software clear.
always @(posedge REF_CLK_IN or negedge NRST_IN) begin
  if (!NRST_IN) begin
    ctrl <= `LSP_CONTROL_RESET; // see [RQ23]
    aux <= `LSP_AUX_RESET;
  end else if (CE_IN) begin
    if (wr_ctrl) begin
      ctrl <= WDATA_IN;
    end
    if (wr_aux) begin
      aux <= WDATA_IN;
    end
    if (set_rx9) begin
      ctrl[`LSP_BIT_RX9] <= rx9_val; // see [RQ16]
    end
    if (set_tx) begin
      ctrl[`LSP_BIT_TXDONE] <= 1'b1; // see [RQ18]
    end
    if (set_rx) begin
      ctrl[`LSP_BIT_RXDONE] <= 1'b1; // see [RQ19]
    end
  end
end
always @(posedge REF_CLK_IN or negedge NRST_IN) begin
  if (!NRST_IN) begin
    RDATA_OUT <= 8'h00;
    SERIAL_OUT_PIN_OUT <= 1'b1;
    SERIAL_IN_PIN_OUT <= 1'b1;
    SERIAL_IN_PIN_OE_OUT <= 1'b0;
    IRQ_OUT <= 1'b0;
    IRQ_PRIO_OUT <= 1'b0;
  end else if (CE_IN) begin
    if (RD_IN && ADDR_IN == `LSP_ADDR_CONTROL) begin
      RDATA_OUT <= ctrl;
    end else if (RD_IN && ADDR_IN == `LSP_ADDR_BUFFER) begin
      RDATA_OUT <= rx_hold; // see [RQ2]
    end else if (RD_IN && ADDR_IN == `LSP_ADDR_AUX) begin
      RDATA_OUT <= aux;
    end else begin
      RDATA_OUT <= 8'h00;
    end
    // Shift clock idles high; data pin driven low only (open drain).
    if (shift_mode) begin
      // On transmit the clock waits for the first phase boundary so bit 0 gets exactly one fall; in RX_DATA it starts at once.
      SERIAL_OUT_PIN_OUT <= !((tx_busy && tx_sub != 4'h0) || rx_state == RX_DATA) ||
                            sh_cnt < 4'h6; // see [RQ5]
      SERIAL_IN_PIN_OUT <= 1'b0;
      SERIAL_IN_PIN_OE_OUT <= tx_busy && !tx_shreg[0]; // see [RQ21]
    end else begin
      SERIAL_OUT_PIN_OUT <= tx_shreg[0];
      SERIAL_IN_PIN_OUT <= 1'b1;
      SERIAL_IN_PIN_OE_OUT <= 1'b0;
    end
    IRQ_OUT <= aux[`LSP_BIT_IEN] &&
               (ctrl[`LSP_BIT_TXDONE] || ctrl[`LSP_BIT_RXDONE]); // see [RQ20]
    IRQ_PRIO_OUT <= aux[`LSP_BIT_IPRI];
  end
end
endmodule

// ### core/lsp_uart_consts.vh
`ifndef LSP_UART_CONSTS_VH
`define LSP_UART_CONSTS_VH
`define LSP_ADDR_CONTROL 8'h98
`define LSP_ADDR_BUFFER 8'h99
`define LSP_ADDR_AUX 8'h9A
`define LSP_BIT_MODE_HI 7
`define LSP_BIT_MODE_LO 6
`define LSP_BIT_MPF 5
`define LSP_BIT_REN 4
`define LSP_BIT_TX9 3
`define LSP_BIT_RX9 2
`define LSP_BIT_TXDONE 1
`define LSP_BIT_RXDONE 0
`define LSP_BIT_DOUBLER 0
`define LSP_BIT_RXT2 1
`define LSP_BIT_TXT2 2
`define LSP_BIT_IEN 3
`define LSP_BIT_IPRI 4
`define LSP_CONTROL_RESET 8'h00
`define LSP_AUX_RESET 8'h00
`define LSP_SHIFT_DIV 4'hC
`define LSP_FIX_DIV_SLOW 7'h04
`define LSP_FIX_DIV_FAST 7'h02
`define LSP_OVF_PER_BIT 5'h10
`endif

// ### tb/lsp_uart_props.sv
`timescale 1ns/100ps
module lsp_uart_props (
  input wire REF_CLK_IN,
  input wire NRST_IN,
  input wire [7:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire [7:0] RDATA_OUT,
  input wire SERIAL_IN_PIN_OUT,
  input wire SERIAL_IN_PIN_OE_OUT,
  input wire SERIAL_OUT_PIN_OUT,
  input wire IRQ_OUT,
  input wire IRQ_PRIO_OUT
);
  // Shadows of bits that only software changes.
  reg [4:0] sw;
  reg ien;
  always @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sw <= 5'h00;
      ien <= 1'b0;
    end else if (WR_IN && ADDR_IN == 8'h98) begin
      sw <= WDATA_IN[7:3];
    end else if (WR_IN && ADDR_IN == 8'h9A) begin
      ien <= WDATA_IN[3];
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  sequence s_no_fall;
    !$fell(SERIAL_OUT_PIN_OUT);
  endsequence
  chk_rst_idle:
    assert property ($rose(NRST_IN) |-> SERIAL_OUT_PIN_OUT && !IRQ_OUT) else $error("not idle");
  chk_rd_idle:
    assert property (!RD_IN |=> RDATA_OUT == 8'h00) else $error("stray read data");
  chk_rd_unmapped:
    assert property (RD_IN && (ADDR_IN < 8'h98 || ADDR_IN > 8'h9A) |=> RDATA_OUT == 8'h00)
      else $error("unmapped read");
  chk_ctrl_readback:
    assert property (RD_IN && ADDR_IN == 8'h98 |=> RDATA_OUT[7:3] == $past(sw))
      else $error("control bits");
  chk_irq_masked:
    assert property (!ien && !$past(ien) |-> !IRQ_OUT) else $error("irq while off");
  chk_prio_follow:
    assert property (WR_IN && ADDR_IN == 8'h9A |-> ##2 IRQ_PRIO_OUT == $past(WDATA_IN[4], 2))
      else $error("priority");
  chk_od_low:
    assert property (SERIAL_IN_PIN_OE_OUT |-> !SERIAL_IN_PIN_OUT) else $error("drives high");
  chk_shift_period:
    assert property (sw[4:3] == 2'b00 && $fell(SERIAL_OUT_PIN_OUT) |=>
      s_no_fall[*8] ##1 s_no_fall[*3]) else $error("shift clock fast");
endmodule
bind lsp_uart lsp_uart_props u_props (
  .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .SERIAL_IN_PIN_OUT(SERIAL_IN_PIN_OUT),
  .SERIAL_IN_PIN_OE_OUT(SERIAL_IN_PIN_OE_OUT), .SERIAL_OUT_PIN_OUT(SERIAL_OUT_PIN_OUT),
  .IRQ_OUT(IRQ_OUT), .IRQ_PRIO_OUT(IRQ_PRIO_OUT));

// ### tb/lsp_peer.sv
`timescale 1ns/100ps
module lsp_peer (
  input wire clk_in,
  input wire tx_in,
  input wire line_in,
  output reg drv_out
);
  initial drv_out = 1'b1;
  task send(input [10:0] v, input int n, input int p);
    for (int i = 0; i < n; i++) begin
      drv_out <= v[i];
      repeat (p) @(posedge clk_in);
    end
    drv_out <= 1'b1;
  endtask
  // Sampling mid-bit keeps clear of the moments the line moves.
  task grab(input int n, input int p, output [10:0] v);
    v = 11'h000;
    while (tx_in) @(posedge clk_in);
    repeat (p / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      v[i] = tx_in;
      repeat (p) @(posedge clk_in);
    end
  endtask
  task shcap(output [7:0] v, output int span);
    time t0;
    for (int i = 0; i < 8; i++) begin
      @(negedge tx_in);
      v[i] = line_in;
      if (i == 0) t0 = $time;
    end
    span = int'($time - t0);
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
  reg clk = 0, nrst = 0, wr = 0, rd = 0, t1 = 0, t2 = 0;
  reg [7:0] addr = 8'h00, wdata = 8'h00, b;
  reg [10:0] v;
  wire [7:0] rdata;
  wire sin, sout, soe, so, irq, prio, pdrv;
  int bad_count = 0, check_count = 0, cyc = 0, span;
  reg [15:0] tab[6] = '{16'h8800, 16'h8001, 16'h4001, 16'h4000, 16'h4004, 16'hC805};
  int per[6] = '{64, 32, 64, 128, 48, 48};
  // Pull-up on the open-drain data pin.
  assign sin = pdrv & ~(soe & ~sout);
  lsp_uart u_lsp_uart (.REF_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .T1_OVF_IN(t1),
    .T2_OVF_IN(t2), .SERIAL_IN_PIN_IN(sin), .SERIAL_IN_PIN_OUT(sout),
    .SERIAL_IN_PIN_OE_OUT(soe), .SERIAL_OUT_PIN_OUT(so), .IRQ_OUT(irq), .IRQ_PRIO_OUT(prio));
  lsp_peer u_lsp_peer (.clk_in(clk), .tx_in(so), .line_in(sin), .drv_out(pdrv));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    t1 <= cyc % 4 == 3;
    t2 <= cyc % 3 == 2;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  task finish_test;
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A gap cycle between accesses keeps each strobe a clean single pulse.
  task acc(input w, input [7:0] a, d, m);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (!w) `CHK($sformatf("reg %h", a), d, rdata & m)
  endtask
  task rx(input [7:0] d, input nb);
    u_lsp_peer.send({1'b1, nb, d, 1'b0}, 11, 64);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    acc(0, 8'h98, 8'h00, 8'hFF);
    acc(0, 8'h9B, 8'h00, 8'hFF);
    acc(1, 8'h98, 8'hF8, 8'h00);
    acc(0, 8'h98, 8'hF8, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      acc(1, 8'h98, tab[i][15:8], 8'h00);
      acc(1, 8'h9A, tab[i][7:0], 8'h00);
      acc(1, 8'h99, 8'hA5, 8'h00);
      u_lsp_peer.grab(10 + tab[i][15], per[i], v);
      `CHK("frame", tab[i][15] ? {1'b1, tab[i][11], 8'hA5, 1'b0} : {2'b01, 8'hA5, 1'b0}, v);
      repeat (per[i]) @(posedge clk);
      acc(0, 8'h98, 8'h02, 8'h02);
    end
    acc(1, 8'h98, 8'h00, 8'h00);
    acc(1, 8'h99, 8'h3C, 8'h00);
    u_lsp_peer.shcap(b, span);
    `CHK("shift byte", 8'h3C, b);
    `CHK("shift span", 2100, span);
    repeat (24) @(posedge clk);
    acc(0, 8'h98, 8'h02, 8'h02);
    acc(1, 8'h9A, 8'h00, 8'h00);
    acc(1, 8'h98, 8'h90, 8'h00);
    rx(8'h5A, 1'b1);
    acc(0, 8'h98, 8'h05, 8'h05);
    acc(0, 8'h99, 8'h5A, 8'hFF);
    acc(1, 8'h98, 8'h90, 8'h00);
    rx(8'h11, 1'b0);
    fork
      rx(8'h22, 1'b0);
      begin
        repeat (100) @(posedge clk);
        acc(0, 8'h99, 8'h11, 8'hFF);
        acc(1, 8'h98, 8'h90, 8'h00);
      end
    join
    acc(0, 8'h99, 8'h22, 8'hFF);
    acc(1, 8'h98, 8'hB0, 8'h00);
    u_lsp_peer.send(11'h000, 1, 10);
    u_lsp_peer.send(11'h7FF, 1, 100);
    rx(8'h33, 1'b0);
    acc(0, 8'h98, 8'h00, 8'h01);
    rx(8'h44, 1'b1);
    acc(0, 8'h98, 8'h05, 8'h05);
    acc(1, 8'h9A, 8'h08, 8'h00);
    acc(1, 8'h9A, 8'h18, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq", 1'b1, irq);
    `CHK("prio", 1'b1, prio);
    acc(1, 8'h98, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq", 1'b0, irq);
    finish_test();
  end
endmodule
